// ---- core/ccpm_defs.svh ----
// Constants for the capture/compare/timer configuration block.
// Assumes inclusion by bare name from core/ and tb/ files; definitions only.
`ifndef CCPM_DEFS_SVH
`define CCPM_DEFS_SVH

// ==========================================================================
// Register map (byte addresses on the plain register port)
`define CCPM_ADDR_W          8
`define CCPM_ADDR_CTRL_LOW   8'h00
`define CCPM_ADDR_CTRL_HIGH  8'h04
`define CCPM_ADDR_PERIOD     8'h08
`define CCPM_ADDR_CMP_A      8'h0C
`define CCPM_ADDR_CMP_B      8'h10
`define CCPM_ADDR_TIMER      8'h14
`define CCPM_ADDR_CAPTURE    8'h18
`define CCPM_ADDR_AUX_SEL    8'h1C
`define CCPM_ADDR_STATUS     8'h20

// ==========================================================================
// Reset values
`define CCPM_CTRL_RST        16'h0000
`define CCPM_PERIOD_RST      32'hFFFFFFFF
`define CCPM_WORD_RST        32'h00000000

// ==========================================================================
// Field positions in the first control word, low half
`define CCPM_ENABLE_BIT      15
`define CCPM_LOW_WMASK       16'hBFFF
`define CCPM_CLKSEL_HI       10
`define CCPM_CLKSEL_LO       8
`define CCPM_PRESCALE_HI     7
`define CCPM_PRESCALE_LO     6
`define CCPM_WIDE_BIT        5
`define CCPM_CAPSEL_BIT      4
`define CCPM_FUNC_HI         3
`define CCPM_FUNC_LO         0

// Field positions in the first control word, high half
`define CCPM_HIGH_WMASK      16'hCFFF
`define CCPM_POST_HI         11
`define CCPM_POST_LO         8

// ==========================================================================
// Time base clock source and prescale codes
`define CCPM_CLK_SYSTEM      3'h0
`define CCPM_CLK_DOUBLE      3'h4
`define CCPM_PRE_DIV1        2'h0
`define CCPM_PRE_DIV4        2'h1
`define CCPM_PRE_DIV16       2'h2
`define CCPM_PRE_DIV64       2'h3
`define CCPM_LIMIT_1         7'h01
`define CCPM_LIMIT_4         7'h04
`define CCPM_LIMIT_16        7'h10
`define CCPM_LIMIT_64        7'h40

// ==========================================================================
// Operating function codes
`define CCPM_CAP_BOTH_DETECT 4'h0
`define CCPM_CAP_RISE        4'h1
`define CCPM_CAP_FALL        4'h2
`define CCPM_CAP_BOTH        4'h3
`define CCPM_CAP_EVERY4      4'h4
`define CCPM_CAP_EVERY16     4'h5
`define CCPM_CMP_TIMER_ONLY  4'h0
`define CCPM_CMP_SET_HIGH    4'h1
`define CCPM_CMP_SET_LOW     4'h2
`define CCPM_CMP_TOGGLE      4'h3
`define CCPM_CMP_DUAL        4'h4
`define CCPM_CMP_DUAL_BUF    4'h5
`define CCPM_CMP_CENTER_BUF  4'h6
`define CCPM_CMP_VAR_FREQ    4'h7
`define CCPM_CMP_EXTERNAL    4'hF

`define CCPM_NARROW_MASK     32'h0000FFFF
`define CCPM_FULL_MASK       32'hFFFFFFFF

`endif

// ---- core/ccpm_pkg.sv ----
// Types shared by the capture/compare/timer configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package ccpm_pkg;

   // =======================================================================
   // Complete register state of the block
   typedef struct packed {
      logic [15:0] ctrlLow;
      logic [15:0] ctrlHigh;
      logic [31:0] period;
      logic [31:0] cmpA;
      logic [31:0] cmpB;
      logic [31:0] bufA;
      logic [31:0] bufB;
      logic [2:0]  extSel;
      logic [31:0] timer;
      logic [6:0]  preAcc;
      logic [31:0] capValue;
      logic        capPrev;
      logic [3:0]  edgeCount;
      logic [3:0]  postCount;
      logic [32:0] freqAcc;
      logic        outLevel;
      logic        capturePulse;
      logic        eventPulse;
      logic [31:0] readData;
   } ccpm_state_t;

endpackage

// ---- core/ccpm_core.sv ----
// Capture/compare/timer block: time base with prescaler, input capture
// and output compare operating functions, and event postscaler.
// Assumes all inputs are synchronous to clk and the register port master
// never asserts both strobes in one cycle.
//
// Notes on behaviour
// - Prescale codes divide by 1, 4, 16, 64.
// - Capture select picks capture mode decode.
// - Capture code 0101: every sixteenth rising edge.
// - Capture code 0100: every fourth rising edge.
// - Capture code 0011: every rising and falling edge.
// - Capture code 0010: every falling edge.
// - Capture code 0001: every rising edge.
// - Capture code 0000: edge detect, both edges.
// - Capture deselected picks compare/timer decode.
// - Code 1111: output from selected external source.
// - Code 0111: variable frequency pulse output.
// - Code 0110: center-aligned pulse, buffered compares.
// - Center-aligned only on multi-output variant.
// - Code 0101: dual-edge compare, buffered values.
// - Code 0100: dual-edge compare, unbuffered values.
// - Code 0011: toggle output on match.
// - Code 0010: drive output low on match.
// - Code 0001: drive output high on match.
// - Code 0000: plain timer, outputs off.
// - Clock source 100: double-rate time base.
// - Postscale N: event every N+1 period matches, or every N+1 captures in capture mode.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ccpm_defs.svh"

module ccpm_core
   import ccpm_pkg::*;
#(
   parameter logic MULTI_OUTPUT = 1'b1
) (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     reset,
   // Register port
   input  wire logic [`CCPM_ADDR_W-1:0]  regAddr,
   input  wire logic [31:0]              regWriteData,
   input  wire logic                     regWrite,
   input  wire logic                     regRead,
   output logic      [31:0]              regReadData,
   // Time base clock sources, one tick strobe per source code
   input  wire logic [7:0]               clockSourceTick,
   // Pins and external sources
   input  wire logic                     captureIn,
   input  wire logic [7:0]               extSource,
   output logic                          compareOut,
   // Events
   output logic                          captureEvent,
   output logic                          moduleEvent
);

   // =======================================================================
   // Decoding helpers

   function automatic logic [31:0] widthMask(input logic [15:0] ctrl,
                                             input logic [31:0] value);
      if (ctrl[`CCPM_WIDE_BIT]) begin
         widthMask = value & `CCPM_FULL_MASK;
      end else begin
         widthMask = value & `CCPM_NARROW_MASK;
      end
   endfunction

   function automatic logic [6:0] prescaleLimit(input logic [1:0] code);
      case (code)
         `CCPM_PRE_DIV1:  prescaleLimit = `CCPM_LIMIT_1;
         `CCPM_PRE_DIV4:  prescaleLimit = `CCPM_LIMIT_4;
         `CCPM_PRE_DIV16: prescaleLimit = `CCPM_LIMIT_16;
         default:         prescaleLimit = `CCPM_LIMIT_64;
      endcase
   endfunction

   // =======================================================================
   // State

   ccpm_state_t s;
   ccpm_state_t next_s;

   logic        enabled;
   logic        captureMode;
   logic [3:0]  func;
   logic [2:0]  clockSel;
   logic [3:0]  postLimit;
   logic [1:0]  inc;
   logic [6:0]  limit;
   logic [6:0]  accSum;
   logic [1:0]  step;
   logic [32:0] timerSum;
   logic [31:0] periodEff;
   logic [31:0] timerNext;
   logic        periodMatch;
   logic        buffered;
   logic [31:0] cmpAEff;
   logic [31:0] cmpBEff;
   logic        matchA;
   logic        matchB;
   logic        riseEdge;
   logic        fallEdge;
   logic        capEvent;
   logic        postSource;

   assign enabled     = s.ctrlLow[`CCPM_ENABLE_BIT];
   assign captureMode = s.ctrlLow[`CCPM_CAPSEL_BIT];
   assign func        = s.ctrlLow[`CCPM_FUNC_HI:`CCPM_FUNC_LO];
   assign clockSel    = s.ctrlLow[`CCPM_CLKSEL_HI:`CCPM_CLKSEL_LO];
   assign postLimit   = s.ctrlHigh[`CCPM_POST_HI:`CCPM_POST_LO];

   // =======================================================================
   // Time base: source, prescaler and counter

   always_comb begin
      if (clockSel == `CCPM_CLK_SYSTEM) begin
         inc = 2'h1;
      end else if (clockSel == `CCPM_CLK_DOUBLE) begin
         inc = 2'h2;
      end else begin
         inc = {1'b0, clockSourceTick[clockSel]};
      end
      limit  = prescaleLimit(s.ctrlLow[`CCPM_PRESCALE_HI:`CCPM_PRESCALE_LO]);
      accSum = s.preAcc + {5'h00, inc};
      if (limit == `CCPM_LIMIT_1) begin
         step = inc;
      end else if (accSum >= limit) begin
         step = 2'h1;
      end else begin
         step = 2'h0;
      end
      // Counter rolls to zero after it has stood at the period value.
      periodEff = widthMask(s.ctrlLow, s.period);
      timerSum  = {1'b0, s.timer} + {31'h00000000, step};
      if (timerSum > {1'b0, periodEff}) begin
         timerNext   = 32'(timerSum - {1'b0, periodEff} - 33'h000000001);
         periodMatch = 1'b1;
      end else begin
         timerNext   = widthMask(s.ctrlLow, timerSum[31:0]);
         periodMatch = 1'b0;
      end
      if (!enabled) begin
         periodMatch = 1'b0;
      end
   end

   // =======================================================================
   // Compare matching
   // At double rate with 1:1 prescale the counter moves by two, so a
   // compare value it jumps over gives no match; software must avoid it.

   always_comb begin
      buffered = (func == `CCPM_CMP_DUAL_BUF) || (func == `CCPM_CMP_CENTER_BUF);
      cmpAEff  = widthMask(s.ctrlLow, buffered ? s.bufA : s.cmpA);
      cmpBEff  = widthMask(s.ctrlLow, buffered ? s.bufB : s.cmpB);
      matchA   = enabled && (step != 2'h0) && (timerNext == cmpAEff);
      matchB   = enabled && (step != 2'h0) && (timerNext == cmpBEff);
   end

   // =======================================================================
   // Capture edge decode

   always_comb begin
      riseEdge = captureIn && !s.capPrev;
      fallEdge = !captureIn && s.capPrev;
      capEvent = 1'b0;
      if (enabled && captureMode) begin
         case (func)
            `CCPM_CAP_BOTH_DETECT: capEvent = riseEdge || fallEdge;
            `CCPM_CAP_RISE:        capEvent = riseEdge;
            `CCPM_CAP_FALL:        capEvent = fallEdge;
            `CCPM_CAP_BOTH:        capEvent = riseEdge || fallEdge;
            `CCPM_CAP_EVERY4:      capEvent = riseEdge && (s.edgeCount[1:0] == 2'h3);
            `CCPM_CAP_EVERY16:     capEvent = riseEdge && (s.edgeCount == 4'hF);
            default:               capEvent = 1'b0;
         endcase
      end
      postSource = captureMode ? capEvent : periodMatch;
   end

   // =======================================================================
   // Next state

   always_comb begin
      next_s              = s;
      next_s.capturePulse = 1'b0;
      next_s.eventPulse   = 1'b0;
      next_s.readData     = `CCPM_WORD_RST;
      next_s.capPrev      = captureIn;

      if (regRead) begin
         case (regAddr)
            `CCPM_ADDR_CTRL_LOW:  next_s.readData = {16'h0000, s.ctrlLow};
            `CCPM_ADDR_CTRL_HIGH: next_s.readData = {16'h0000, s.ctrlHigh};
            `CCPM_ADDR_PERIOD:    next_s.readData = s.period;
            `CCPM_ADDR_CMP_A:     next_s.readData = s.cmpA;
            `CCPM_ADDR_CMP_B:     next_s.readData = s.cmpB;
            `CCPM_ADDR_TIMER:     next_s.readData = s.timer;
            `CCPM_ADDR_CAPTURE:   next_s.readData = s.capValue;
            `CCPM_ADDR_AUX_SEL:   next_s.readData = {29'h00000000, s.extSel};
            `CCPM_ADDR_STATUS:    next_s.readData = {24'h000000, s.postCount,
                                                     3'h0, s.outLevel};
            default:              next_s.readData = `CCPM_WORD_RST;
         endcase
      end

      // Time base advances, or is held cleared while the module is off.
      if (enabled) begin
         next_s.timer  = timerNext;
         next_s.preAcc = (limit != `CCPM_LIMIT_1) && (accSum >= limit)
                         ? 7'(accSum - limit)
                         : ((limit == `CCPM_LIMIT_1) ? 7'h00 : accSum);
      end else begin
         next_s.timer  = `CCPM_WORD_RST;
         next_s.preAcc = 7'h00;
      end

      // Buffered compare values take effect at a period boundary or while the module is off.
      if (periodMatch || !enabled) begin
         next_s.bufA = s.cmpA;
         next_s.bufB = s.cmpB;
      end

      // Input capture.
      if (enabled && captureMode && riseEdge) begin
         next_s.edgeCount = s.edgeCount + 4'h1;
      end
      if (capEvent) begin
         next_s.capValue     = s.timer;
         next_s.capturePulse = 1'b1;
      end

      if (postSource) begin
         if (s.postCount == postLimit) begin
            next_s.postCount  = 4'h0;
            next_s.eventPulse = 1'b1;
         end else begin
            next_s.postCount = s.postCount + 4'h1;
         end
      end

      next_s.freqAcc = {1'b0, s.freqAcc[31:0]};
      if (!enabled) begin
         next_s.outLevel = 1'b0;
      end else if (!captureMode) begin
         case (func)
            `CCPM_CMP_TIMER_ONLY: next_s.outLevel = 1'b0;
            `CCPM_CMP_SET_HIGH: begin
               if (matchA) begin
                  next_s.outLevel = 1'b1;
               end
            end
            `CCPM_CMP_SET_LOW: begin
               if (matchA) begin
                  next_s.outLevel = 1'b0;
               end
            end
            `CCPM_CMP_TOGGLE: begin
               if (matchA) begin
                  next_s.outLevel = !s.outLevel;
               end
            end
            // Dual edge, direct values; buffered values
            `CCPM_CMP_DUAL, `CCPM_CMP_DUAL_BUF: begin
               if (matchB) begin
                  next_s.outLevel = 1'b0;
               end else if (matchA) begin
                  next_s.outLevel = 1'b1;
               end
            end
            // Center pulse from buffered edges; variant gate
            `CCPM_CMP_CENTER_BUF: begin
               if (MULTI_OUTPUT && matchB) begin
                  next_s.outLevel = 1'b0;
               end else if (MULTI_OUTPUT && matchA) begin
                  next_s.outLevel = 1'b1;
               end
            end
            `CCPM_CMP_VAR_FREQ: begin
               if (step != 2'h0) begin
                  next_s.freqAcc  = {1'b0, widthMask(s.ctrlLow, s.freqAcc[31:0])}
                                    + {1'b0, widthMask(s.ctrlLow, s.cmpA)};
                  next_s.outLevel = s.ctrlLow[`CCPM_WIDE_BIT]
                                    ? next_s.freqAcc[32] : next_s.freqAcc[16];
                  next_s.freqAcc  = {1'b0, widthMask(s.ctrlLow,
                                                     next_s.freqAcc[31:0])};
               end else begin
                  next_s.outLevel = 1'b0;
               end
            end
            `CCPM_CMP_EXTERNAL: next_s.outLevel = extSource[s.extSel];
            // Reserved compare codes hold the output
            default: next_s.outLevel = s.outLevel;
         endcase
      end

      // Writes are applied last so software sees its own value, less any bits the write mask clears.
      if (regWrite) begin
         case (regAddr)
            `CCPM_ADDR_CTRL_LOW:  next_s.ctrlLow  = regWriteData[15:0] & `CCPM_LOW_WMASK;
            `CCPM_ADDR_CTRL_HIGH: next_s.ctrlHigh = regWriteData[15:0] & `CCPM_HIGH_WMASK;
            `CCPM_ADDR_PERIOD:    next_s.period   = regWriteData;
            `CCPM_ADDR_CMP_A:     next_s.cmpA     = regWriteData;
            `CCPM_ADDR_CMP_B:     next_s.cmpB     = regWriteData;
            `CCPM_ADDR_AUX_SEL:   next_s.extSel   = regWriteData[2:0];
            default:              next_s.extSel   = next_s.extSel;
         endcase
      end
   end

   // =======================================================================
   // Registers

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s          <= '0;
         s.ctrlLow  <= `CCPM_CTRL_RST;
         s.ctrlHigh <= `CCPM_CTRL_RST;
         s.period   <= `CCPM_PERIOD_RST;
         s.bufA     <= `CCPM_WORD_RST;
      end else begin
         s <= next_s;
      end
   end

   assign regReadData  = s.readData;
   assign compareOut   = s.outLevel;
   assign captureEvent = s.capturePulse;
   assign moduleEvent  = s.eventPulse;

endmodule // ccpm_core

`default_nettype wire

// ---- tb/ccpm_core_props.sv ----
// Checker for the capture/compare/timer block, seeing only its ports.
// Assumes control words change only through the register port.
`timescale 1ns/1ps
`default_nettype none
`include "ccpm_defs.svh"

module ccpm_core_props (
   // Clock and reset
   input wire logic                    clk,
   input wire logic                    reset,
   // Register port
   input wire logic [`CCPM_ADDR_W-1:0] regAddr,
   input wire logic [31:0]             regWriteData,
   input wire logic                    regWrite,
   input wire logic                    regRead,
   input wire logic [31:0]             regReadData,
   // Pins and events
   input wire logic                    captureIn,
   input wire logic [7:0]              extSource,
   input wire logic                    compareOut,
   input wire logic                    captureEvent
);
   logic [15:0] ctrl;
   logic [2:0]  aux;
   logic        on;
   logic [4:0]  md;
   logic        mRise;
   logic        mFall;
   logic        mHigh;
   logic        mLow;

   // ======================================================================
   // Shadow of the low control word and the auxiliary select, rebuilt from the write strobes.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl <= 16'h0000;
         aux <= 3'h0;
      end else if (regWrite) begin
         if (regAddr == `CCPM_ADDR_CTRL_LOW) ctrl <= regWriteData[15:0] & `CCPM_LOW_WMASK;
         if (regAddr == `CCPM_ADDR_AUX_SEL) aux <= regWriteData[2:0];
      end
   end
   assign on = ctrl[`CCPM_ENABLE_BIT];
   assign md = ctrl[4:0];
   assign mRise = on && md == 5'h11;
   assign mFall = on && md == 5'h12;
   assign mHigh = on && md == 5'h01;
   assign mLow  = on && md == 5'h02;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence sqTimerOnly;
      (on && md == 5'h00) [*3];
   endsequence
   sequence sqExtSteady;
      (on && md == 5'h0F && $stable(extSource) && $stable(aux)) [*3];
   endsequence

   // ======================================================================
   AST_READ_IDLE: assert property (!$past(regRead) |-> regReadData == 32'h0)
      else $error("read data not zero outside read answer");
   AST_CAP_EDGE: assert property (captureEvent |-> $past(captureIn) != $past(captureIn, 2))
      else $error("capture without input edge");
   AST_CAP_RISE: assert property (captureEvent && $past(mRise) |-> $past(captureIn))
      else $error("rise mode captured a falling edge");
   AST_CAP_FALL: assert property (captureEvent && $past(mFall) |-> !$past(captureIn))
      else $error("fall mode captured a rising edge");
   AST_CAP_MODE: assert property (captureEvent |-> $past(on && ctrl[4] && ctrl[3:0] <= 4'h5))
      else $error("capture outside a valid capture mode");
   AST_TIMER_OFF: assert property (sqTimerOnly |-> !compareOut)
      else $error("output active in timer mode");
   AST_OFF_LOW: assert property ((!on) [*2] |-> !compareOut)
      else $error("output active while disabled");
   AST_SET_HIGH: assert property (mHigh && $past(mHigh && compareOut) |-> compareOut)
      else $error("set-high mode dropped output");
   AST_SET_LOW: assert property (mLow && $past(mLow && !compareOut) |-> !compareOut)
      else $error("set-low mode raised output");
   AST_EXT: assert property (sqExtSteady |-> compareOut == extSource[aux])
      else $error("external mode output differs from source");
endmodule // ccpm_core_props

bind ccpm_core ccpm_core_props uProps (.clk(clk), .reset(reset), .regAddr(regAddr),
   .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
   .regReadData(regReadData), .captureIn(captureIn), .extSource(extSource),
   .compareOut(compareOut), .captureEvent(captureEvent));

`default_nettype wire

// ---- tb/ccpm_pin_model.sv ----
// Model of the pins outside the block: capture input and external sources.
// Assumes the testbench calls its tasks; all changes follow a rising edge.
`timescale 1ns/1ps
`default_nettype none

module ccpm_pin_model (
   // Clock
   input  wire logic      clk,
   // Pins toward the block
   output var logic       captureIn,
   output var logic [7:0] extSource
);
   initial begin
      captureIn = 1'b0;
      extSource = 8'h00;
   end

   // Pulses are two cycles high and two low, so every edge is sampled.
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk);
         captureIn <= 1'b1;
         repeat (2) @(posedge clk);
         captureIn <= 1'b0;
         @(posedge clk);
      end
   endtask

   task automatic setExt(input logic [7:0] v);
      @(posedge clk);
      extSource <= v;
   endtask
endmodule // ccpm_pin_model

`default_nettype wire

// ---- tb/ccpm_core_tb.sv ----
// Self-checking testbench for the capture/compare/timer block.
// Assumes the checker is bound to the block and the pin model drives pins.
`timescale 1ns/1ps
`default_nettype none
`include "ccpm_defs.svh"

module ccpm_core_tb;
   logic        clk;
   logic        reset;
   logic [7:0]  regAddr;
   logic [31:0] regWriteData;
   logic        regWrite;
   logic        regRead;
   logic [31:0] regReadData;
   logic        captureIn;
   logic [7:0]  extSource;
   logic        compareOut;
   logic        captureEvent;
   logic        moduleEvent;
   int          err_total = 0;
   int          n_tests = 0;
   int          capCount = 0;
   int          evtCount = 0;
   int          capExp[9] = '{32, 16, 16, 32, 4, 1, 0, 0, 0};

   ccpm_core #(.MULTI_OUTPUT(1'b1)) DUT (.clk(clk), .reset(reset), .regAddr(regAddr),
      .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
      .regReadData(regReadData), .clockSourceTick(8'h00), .captureIn(captureIn),
      .extSource(extSource), .compareOut(compareOut), .captureEvent(captureEvent),
      .moduleEvent(moduleEvent));
   ccpm_pin_model pin (.clk(clk), .captureIn(captureIn), .extSource(extSource));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (captureEvent === 1'b1) capCount++;
      if (moduleEvent === 1'b1) evtCount++;
   end

   // ======================================================================
   task automatic conclude();
      if (err_total == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWriteData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 d = regReadData;
   endtask
   task automatic watch(input int n, output int hi, output int ch);
      logic prev;
      hi = 0;
      ch = 0;
      prev = compareOut;
      repeat (n) begin
         @(posedge clk);
         #1 if (compareOut === 1'b1) hi++;
         if (compareOut !== prev) ch++;
         prev = compareOut;
      end
   endtask

   // ======================================================================
   task automatic t_regs();
      logic [31:0] d;
      rd(`CCPM_ADDR_CTRL_LOW, d);
      chk(d, 32'h0);
      rd(`CCPM_ADDR_PERIOD, d);
      chk(d, 32'hFFFFFFFF);
      rd(8'h40, d);
      chk(d, 32'h0);
      wr(`CCPM_ADDR_CTRL_LOW, 32'h7FFF);
      rd(`CCPM_ADDR_CTRL_LOW, d);
      chk(d, 32'h3FFF);
      wr(`CCPM_ADDR_CTRL_HIGH, 32'hFFFF);
      rd(`CCPM_ADDR_CTRL_HIGH, d);
      chk(d, 32'hCFFF);
      wr(`CCPM_ADDR_CTRL_LOW, 32'h0);
   endtask
   task automatic t_rate(input logic [15:0] c, input logic [31:0] e);
      logic [31:0] a;
      logic [31:0] b;
      wr(`CCPM_ADDR_CTRL_LOW, 32'h0);
      wr(`CCPM_ADDR_CTRL_LOW, {16'h0, c});
      repeat (80) @(posedge clk);
      rd(`CCPM_ADDR_TIMER, a);
      repeat (126) @(posedge clk);
      rd(`CCPM_ADDR_TIMER, b);
      chk((b - a) & 32'hFFFF, e);
   endtask
   task automatic t_cap();
      for (int c = 0; c < 9; c++) begin
         wr(`CCPM_ADDR_CTRL_LOW, 32'h8010 | c);
         capCount = 0;
         pin.pulses(16);
         repeat (4) @(posedge clk);
         chk(capCount, capExp[c]);
      end
      wr(`CCPM_ADDR_CTRL_LOW, 32'h0);
   endtask
   task automatic t_cmp();
      int hi;
      int ch;
      wr(`CCPM_ADDR_PERIOD, 32'h9);
      wr(`CCPM_ADDR_CMP_A, 32'h2);
      wr(`CCPM_ADDR_CMP_B, 32'h6);
      for (int m = 0; m < 7; m++) begin
         wr(`CCPM_ADDR_CTRL_LOW, 32'h8000 | m);
         repeat (30) @(posedge clk);
         watch(20, hi, ch);
         case (m)
            0: chk(hi, 0);
            1: chk(hi, 20);
            2: chk(hi, 0);
            3: chk(ch, 2);
            default: chk(hi, 8);
         endcase
      end
      wr(`CCPM_ADDR_CMP_A, 32'h40000000);
      wr(`CCPM_ADDR_CTRL_LOW, 32'h8027);
      repeat (10) @(posedge clk);
      watch(32, hi, ch);
      chk(hi, 8);
      wr(`CCPM_ADDR_AUX_SEL, 32'h5);
      wr(`CCPM_ADDR_CTRL_LOW, 32'h800F);
      pin.setExt(8'h20);
      repeat (4) @(posedge clk);
      chk(compareOut, 1);
      pin.setExt(8'hDF);
      repeat (4) @(posedge clk);
      chk(compareOut, 0);
      wr(`CCPM_ADDR_CTRL_LOW, 32'h0);
   endtask
   task automatic t_post(input logic [3:0] p);
      wr(`CCPM_ADDR_PERIOD, 32'h9);
      wr(`CCPM_ADDR_CTRL_HIGH, {20'h0, p, 8'h00});
      wr(`CCPM_ADDR_CTRL_LOW, 32'h8000);
      repeat (200) @(posedge clk);
      // Clear and read the count off the edge so the counting process never races them.
      #1 evtCount = 0;
      repeat (40 * (p + 1)) @(posedge clk);
      #1 chk(evtCount, 4);
      wr(`CCPM_ADDR_CTRL_LOW, 32'h0);
   endtask

   // ======================================================================
   initial begin
      reset = 1'b1;
      regAddr = 8'h00;
      regWriteData = 32'h0;
      regWrite = 1'b0;
      regRead = 1'b0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      for (int p = 0; p < 4; p++) t_rate(16'h8000 | (p << 6), 32'd128 >> (2 * p));
      t_rate(16'h8400, 32'd256);
      t_cap();
      t_cmp();
      t_post(4'h3);
      t_post(4'hF);
      conclude();
   end
   // A hang counts as a mismatch and ends through the same closing task.
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      conclude();
   end
endmodule // ccpm_core_tb

`default_nettype wire
